// [hw/wpd_pkg.sv]
/*
   Constants for the wakeup and port direction block: register offsets,
   field positions, reset values and the oscillator warm-up count.
   Assumes an 8-bit register address and 8-bit register data.
*/
`default_nettype none

package wpd_pkg;

   // register offsets on the 8-bit register port
   localparam logic [7:0] OFS_P0_DIR = 8'hB8;
   localparam logic [7:0] OFS_P1_WAKE = 8'hC0;
   localparam logic [7:0] OFS_P1_DIR = 8'hC1;
   localparam logic [7:0] OFS_P3_DIR = 8'hC3;
   localparam logic [7:0] OFS_P5_DIR = 8'hC5;
   localparam logic [7:0] OFS_CPU_CTRL = 8'h80;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h81;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h82;
   localparam logic [7:0] OFS_STATE = 8'h83;

   // implemented bits of each register
   localparam logic [7:0] P0_DIR_MASK = 8'h0B;
   localparam logic [7:0] P0_DIR_FIXED = 8'h04;
   localparam logic [7:0] P1_MASK = 8'h7F;
   localparam logic [7:0] P3_MASK = 8'hFF;
   localparam logic [7:0] P5_MASK = 8'h3F;
   localparam logic [7:0] P0_WAKE_MASK = 8'h0F;

   // reset values
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] WAKE_EN_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // cpu control register fields
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_MODE_HI = 1;
   localparam int CTRL_SLOW = 2;
   localparam int CTRL_TMR_EN = 3;
   localparam int CTRL_P3_SEG = 4;

   // operating-mode field codes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SLEEP = 2'h1;
   localparam logic [1:0] MODE_GREEN = 2'h2;

   // interrupt status bit positions
   localparam int IRQ_PIN_WAKE = 0;
   localparam int IRQ_TMR_WAKE = 1;
   localparam int IRQ_WARM_DONE = 2;

   // oscillator clocks counted after a power-down wake
   localparam int WAKE_OSC_CLKS = 2048;
   localparam logic [10:0] WARM_LAST = 11'(WAKE_OSC_CLKS - 1);

   typedef enum logic [1:0] {
      ST_RUN,
      ST_GREEN,
      ST_SLEEP,
      ST_WARM
   } wpd_state_t;

endpackage

`default_nettype wire

// [hw/wpd_top.sv]
/*
   Wakeup sequencer and port direction registers of a small 8-bit
   controller: halts the cpu in sleep and green modes, wakes on pin
   level change or timer overflow, times oscillator warm-up, holds the
   port 1 wake enables and the port 0/1/3/5 direction bits.
   Assumes pin levels and the timer overflow pulse are synchronous to
   CLK_I, and that CLK_I stands for the high-speed oscillator clock.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - cpu halt output stays high in sleep, warm-up and green states.
// - sleep ends only on port 0 or enabled port 1 level change.
// - green returns to prior normal or slow mode on pin or timer wake.
// - timer overflow wakes green only while the timer enable bit is set.
// - oscillator stop output is high while in sleep.
// - after sleep wake, count 2048 oscillator clocks before resuming.
// - green wake resumes at once with no warm-up.
// - port 0 wake detection always on; pull-ups are software's job.
// - port 1 wake enable bits 6..0 gate each pin's wake; reset clear.
// - direction bit 0 means input, 1 means output.
// - all direction bits reset to input.
// - port 0 pin 2 input only; its direction bit reads one.
// - port 3 segment select bit chooses segment or general I/O.
// - port 3 comes up as input after reset.
// - mode field 01 is sleep, 00 normal, 11 reserved.
module wpd_top
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic [3:0] P0_PIN_I,
   input wire logic [6:0] P1_PIN_I,
   input wire logic TMR_OVF_I,
   output logic CPU_HALT_O,
   output logic HOSC_STOP_O,
   output logic SLOW_MODE_O,
   output logic [3:0] P0_DIR_O,
   output logic [6:0] P1_DIR_O,
   output logic [7:0] P3_DIR_O,
   output logic [5:0] P5_DIR_O,
   output logic P3_SEG_SEL_O,
   output logic [1:0] CPU_MODE_O,
   output logic IRQ_O
);
   import wpd_pkg::*;

   wpd_state_t state_r;
   wpd_state_t state_nxt;
   logic [7:0] p0_dir_r;
   logic [7:0] p1_wake_r;
   logic [7:0] p1_dir_r;
   logic [7:0] p3_dir_r;
   logic [7:0] p5_dir_r;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_stat_nxt;
   logic [2:0] irq_mask_r;
   logic [3:0] snap0_r;
   logic [6:0] snap1_r;
   logic [10:0] warm_cnt_r;
   logic [10:0] warm_cnt_nxt;
   logic [7:0] rdata_nxt;

   // address decode
   wire sel_p0_dir = (ADDR_I == OFS_P0_DIR);
   wire sel_p1_wake = (ADDR_I == OFS_P1_WAKE);
   wire sel_p1_dir = (ADDR_I == OFS_P1_DIR);
   wire sel_p3_dir = (ADDR_I == OFS_P3_DIR);
   wire sel_p5_dir = (ADDR_I == OFS_P5_DIR);
   wire sel_ctrl = (ADDR_I == OFS_CPU_CTRL);
   wire sel_stat = (ADDR_I == OFS_IRQ_STAT);
   wire sel_mask = (ADDR_I == OFS_IRQ_MASK);
   wire sel_state = (ADDR_I == OFS_STATE);

   wire wr_p0_dir = WR_I & sel_p0_dir;
   wire wr_p1_wake = WR_I & sel_p1_wake;
   wire wr_p1_dir = WR_I & sel_p1_dir;
   wire wr_p3_dir = WR_I & sel_p3_dir;
   wire wr_p5_dir = WR_I & sel_p5_dir;
   wire wr_ctrl = WR_I & sel_ctrl;
   wire wr_stat = WR_I & sel_stat;
   wire wr_mask = WR_I & sel_mask;

   // mode field as written; 11 is reserved and enters no low-power state
   wire [1:0] wr_mode = WDATA_I[CTRL_MODE_HI:CTRL_MODE_LO];
   wire go_sleep = wr_ctrl & (wr_mode == MODE_SLEEP);
   wire go_green = wr_ctrl & (wr_mode == MODE_GREEN);

   // level change against the snapshot taken on entry
   wire [3:0] p0_diff = (P0_PIN_I ^ snap0_r) & P0_WAKE_MASK[3:0];
   wire [6:0] p1_diff = (P1_PIN_I ^ snap1_r) & p1_wake_r[6:0];
   wire pin_wake = (|p0_diff) | (|p1_diff);

   // timer wake is gated by the timer enable bit of the control register, not the interrupt mask
   wire tmr_wake = TMR_OVF_I & ctrl_r[CTRL_TMR_EN];

   wire in_sleep = (state_r == ST_SLEEP);
   wire in_green = (state_r == ST_GREEN);
   wire in_warm = (state_r == ST_WARM);
   wire warm_done = in_warm & (warm_cnt_r == WARM_LAST);

   // wake events for the status register
   wire ev_pin = (in_sleep | in_green) & pin_wake;
   wire ev_tmr = in_green & tmr_wake & ~pin_wake;
   wire [2:0] ev_vec = {warm_done, ev_tmr, ev_pin};

   // state transitions of the low-power sequencer
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN:
         begin
            if (go_sleep)
               state_nxt = ST_SLEEP;
            else if (go_green)
               state_nxt = ST_GREEN;
         end
         ST_SLEEP:
         begin
            // only a pin can end sleep, timer is inactive here
            if (pin_wake)
               state_nxt = ST_WARM;
         end
         ST_WARM:
         begin
            if (warm_done)
               state_nxt = ST_RUN;
         end
         ST_GREEN:
         begin
            // clocks still run, so no warm-up is needed
            if (pin_wake | tmr_wake)
               state_nxt = ST_RUN;
         end
      endcase
   end

   // warm-up counter runs only in the warm-up state
   assign warm_cnt_nxt = in_warm ? warm_cnt_r + 11'h001 : 11'h000;

   // control register; the mode field clears itself on wake
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl && state_r == ST_RUN)
         ctrl_nxt = WDATA_I & 8'h1F;
      if (state_nxt == ST_RUN && state_r != ST_RUN)
      begin
         ctrl_nxt[CTRL_MODE_HI] = 1'b0;
         ctrl_nxt[CTRL_MODE_LO] = 1'b0;
      end
      // sleep always comes back in normal mode
      if (state_nxt == ST_WARM && in_sleep)
         ctrl_nxt[CTRL_SLOW] = 1'b0;
   end

   // sticky status: a new event wins over a write-one clear
   assign irq_stat_nxt = (irq_stat_r & ~(wr_stat ? WDATA_I[2:0] : 3'h0))
                         | ev_vec;

   // read multiplexer; write-only wake register reads as zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (RD_I)
      begin
         if (sel_p0_dir)
            rdata_nxt = (p0_dir_r & P0_DIR_MASK) | P0_DIR_FIXED;
         else if (sel_p1_dir)
            rdata_nxt = p1_dir_r;
         else if (sel_p3_dir)
            rdata_nxt = p3_dir_r;
         else if (sel_p5_dir)
            rdata_nxt = p5_dir_r;
         else if (sel_ctrl)
            rdata_nxt = ctrl_r;
         else if (sel_stat)
            rdata_nxt = {5'h00, irq_stat_r};
         else if (sel_mask)
            rdata_nxt = {5'h00, irq_mask_r};
         else if (sel_state)
            rdata_nxt = {6'h00, state_r};
      end
   end

   // sequencer state, counter and entry snapshot
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         state_r <= ST_RUN;
         warm_cnt_r <= 11'h000;
         snap0_r <= 4'h0;
         snap1_r <= 7'h00;
      end
      else
      begin
         state_r <= state_nxt;
         warm_cnt_r <= warm_cnt_nxt;
         if (state_r == ST_RUN)
         begin
            snap0_r <= P0_PIN_I;
            snap1_r <= P1_PIN_I;
         end
      end
   end

   // direction registers cleared to input, wake enable register cleared to zero
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         p0_dir_r <= DIR_RST;
         p1_dir_r <= DIR_RST;
         p3_dir_r <= DIR_RST;
         p5_dir_r <= DIR_RST;
         p1_wake_r <= WAKE_EN_RST;
      end
      else
      begin
         if (wr_p0_dir)
            p0_dir_r <= WDATA_I & P0_DIR_MASK;
         if (wr_p1_dir)
            p1_dir_r <= WDATA_I & P1_MASK;
         if (wr_p3_dir)
            p3_dir_r <= WDATA_I & P3_MASK;
         if (wr_p5_dir)
            p5_dir_r <= WDATA_I & P5_MASK;
         if (wr_p1_wake)
            p1_wake_r <= WDATA_I & P1_MASK;
      end
   end

   // control, interrupt and read data registers
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         ctrl_r <= CTRL_RST;
         irq_stat_r <= IRQ_RST;
         irq_mask_r <= IRQ_RST;
         RDATA_O <= 8'h00;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         irq_stat_r <= irq_stat_nxt;
         if (wr_mask)
            irq_mask_r <= WDATA_I[2:0];
         RDATA_O <= rdata_nxt;
      end
   end

   // outputs, all registered; halt, stop, slow, mode and irq from next-state values
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         CPU_HALT_O <= 1'b0;
         HOSC_STOP_O <= 1'b0;
         SLOW_MODE_O <= 1'b0;
         P0_DIR_O <= 4'h0;
         P1_DIR_O <= 7'h00;
         P3_DIR_O <= 8'h00;
         P5_DIR_O <= 6'h00;
         P3_SEG_SEL_O <= 1'b0;
         CPU_MODE_O <= MODE_NORMAL;
         IRQ_O <= 1'b0;
      end
      else
      begin
         CPU_HALT_O <= (state_nxt != ST_RUN);
         HOSC_STOP_O <= (state_nxt == ST_SLEEP);
         SLOW_MODE_O <= ctrl_nxt[CTRL_SLOW];
         // pin 2 is never driven whatever the stored bit says
         P0_DIR_O <= p0_dir_r[3:0] & 4'hB;
         P1_DIR_O <= p1_dir_r[6:0];
         P3_DIR_O <= p3_dir_r;
         P5_DIR_O <= p5_dir_r[5:0];
         P3_SEG_SEL_O <= ctrl_r[CTRL_P3_SEG];
         CPU_MODE_O <= ctrl_nxt[CTRL_MODE_HI:CTRL_MODE_LO];
         IRQ_O <= |(irq_stat_nxt & irq_mask_r);
      end
   end

endmodule

`default_nettype wire

// [dv/wpd_checker.sv]
/* port-timing checker for wpd_top
   bound to every wpd_top instance */
`timescale 1ns/100ps
`default_nettype none
module wpd_checker
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic [3:0] P0_PIN_I,
   input wire logic [6:0] P1_PIN_I,
   input wire logic CPU_HALT_O,
   input wire logic HOSC_STOP_O,
   input wire logic [3:0] P0_DIR_O,
   input wire logic [6:0] P1_DIR_O,
   input wire logic [7:0] P3_DIR_O,
   input wire logic [5:0] P5_DIR_O,
   input wire logic [1:0] CPU_MODE_O,
   input wire logic IRQ_O
);
   import wpd_pkg::*;
   logic [3:0] p0_snap_r;
   logic [6:0] p1_snap_r;
   logic warm_r;
   logic [11:0] cnt_r;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // levels frozen at entry, as the wake compare sees them
   always_ff @(posedge CLK_I)
      if (!CPU_HALT_O)
      begin
         p0_snap_r <= P0_PIN_I;
         p1_snap_r <= P1_PIN_I;
      end
   // warm-up length counter; reset wins over a stale fall
   always_ff @(posedge CLK_I)
      if (!RST_N_I || $fell(CPU_HALT_O))
         warm_r <= 1'b0;
      else if ($fell(HOSC_STOP_O))
         warm_r <= 1'b1;
   always_ff @(posedge CLK_I)
      cnt_r <= $fell(HOSC_STOP_O) ? 12'h001 : cnt_r + 12'h001;
   property p_green_halt;
      CPU_MODE_O == MODE_GREEN |-> CPU_HALT_O && !HOSC_STOP_O;
   endproperty
   a_green_halt: assert property (p_green_halt)
      else $error("green without halt");
   property p_sleep_stop;
      HOSC_STOP_O |-> CPU_HALT_O && CPU_MODE_O == MODE_SLEEP;
   endproperty
   a_sleep_stop: assert property (p_sleep_stop)
      else $error("oscillator stop outside sleep");
   property p_sleep_hold;
      HOSC_STOP_O && P0_PIN_I == p0_snap_r && P1_PIN_I == p1_snap_r
         |=> HOSC_STOP_O;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("sleep left without pin change");
   property p_p0_wake;
      HOSC_STOP_O && P0_PIN_I != p0_snap_r |=> !HOSC_STOP_O && CPU_HALT_O;
   endproperty
   a_p0_wake: assert property (p_p0_wake)
      else $error("port 0 change did not wake");
   property p_warm_len;
      warm_r |-> (CPU_HALT_O ? cnt_r < 12'h800 : cnt_r == 12'h800);
   endproperty
   a_warm_len: assert property (p_warm_len)
      else $error("warm-up length wrong");
   property p_green_wake;
      CPU_MODE_O == MODE_GREEN && P0_PIN_I != p0_snap_r
         |=> !CPU_HALT_O && CPU_MODE_O == MODE_NORMAL;
   endproperty
   a_green_wake: assert property (p_green_wake)
      else $error("green wake late");
   property p_rd_idle;
      !RD_I |=> RDATA_O == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside slot");
   property p_p0_fixed;
      P0_DIR_O[2] == 1'b0;
   endproperty
   a_p0_fixed: assert property (p_p0_fixed)
      else $error("input-only pin driven");
   property p_dir_reset;
      $rose(RST_N_I) |-> {P0_DIR_O, P1_DIR_O, P3_DIR_O, P5_DIR_O} == 25'h0;
   endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("direction not input after reset");
   c_warm: cover property ($fell(CPU_HALT_O) && warm_r);
   c_green: cover property (CPU_MODE_O == MODE_GREEN ##1 !CPU_HALT_O);
   c_irq: cover property ($rose(IRQ_O));
endmodule
bind wpd_top wpd_checker u_wpd_checker (.CLK_I, .RST_N_I, .RD_I,
   .RDATA_O, .P0_PIN_I, .P1_PIN_I, .CPU_HALT_O, .HOSC_STOP_O, .P0_DIR_O,
   .P1_DIR_O, .P3_DIR_O, .P5_DIR_O, .CPU_MODE_O, .IRQ_O);
`default_nettype wire

// [dv/wpd_pin_model.sv]
/* far-side pins: pulled high, flip a mask after a lag
   assumes go_i is a one-cycle pulse */
`timescale 1ns/100ps
`default_nettype none
module wpd_pin_model
(
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [10:0] flip_i,
   input wire logic [3:0] lag_i,
   output logic [10:0] pins_o
);
   logic busy_r = 1'b0;
   logic [3:0] wait_r;
   logic [10:0] flip_r;
   // pull-ups on before sleep so idle levels are known
   initial pins_o = 11'h7FF;
   // slow or prompt edge, always synchronous to the clock
   always @(posedge clk_i)
      if (go_i)
      begin
         busy_r <= 1'b1;
         wait_r <= lag_i;
         flip_r <= flip_i;
      end
      else if (busy_r && wait_r != 4'h0)
         wait_r <= wait_r - 4'h1;
      else if (busy_r)
      begin
         busy_r <= 1'b0;
         pins_o <= pins_o ^ flip_r;
      end
endmodule
`default_nettype wire

// [dv/wpd_top_tb.sv]
/* bench for wpd_top: registers, sleep and green wake
   assumes the checker is bound by its own file */
`timescale 1ns/100ps
`default_nettype none
module wpd_top_tb;
   import wpd_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic tmr = 1'b0;
   logic go = 1'b0;
   logic [10:0] flip = 11'h000;
   logic [3:0] lag = 4'h0;
   logic [10:0] pins;
   logic [7:0] rdata, v, p3d;
   logic halt, stop, slow, seg, irq;
   logic [3:0] p0d;
   logic [6:0] p1d;
   logic [5:0] p5d;
   logic [1:0] mode;
   int bad_count = 0;
   int comparisons = 0;
   int n;
   int ticks = 0;
   logic [7:0] ofs [4] = '{OFS_P0_DIR, OFS_P1_DIR, OFS_P3_DIR, OFS_P5_DIR};
   logic [7:0] msk [4] = '{8'h0F, 8'h7F, 8'hFF, 8'h3F};
   wpd_top u_wpd_top (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .P0_PIN_I(pins[3:0]), .P1_PIN_I(pins[10:4]), .TMR_OVF_I(tmr),
      .CPU_HALT_O(halt), .HOSC_STOP_O(stop), .SLOW_MODE_O(slow),
      .P0_DIR_O(p0d), .P1_DIR_O(p1d), .P3_DIR_O(p3d), .P5_DIR_O(p5d),
      .P3_SEG_SEL_O(seg), .CPU_MODE_O(mode), .IRQ_O(irq));
   wpd_pin_model u_wpd_pin_model (.clk_i(clk), .go_i(go), .flip_i(flip),
      .lag_i(lag), .pins_o(pins));
   initial forever #4 clk = ~clk;
   task automatic summarize;
      $display("comparisons %0d errors %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard, well above the 2048-cycle warm-up
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 20000)
      begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(string s, logic [11:0] e, logic [11:0] g);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wrr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(string s, logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
      chk(s, {4'h0, e}, {4'h0, v});
   endtask
   task automatic pin(logic [10:0] f, logic [3:0] l);
      @(posedge clk);
      flip <= f;
      lag <= l;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic ovf;
      @(posedge clk);
      tmr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rchk("dir reset", ofs[i], (i == 0) ? 8'h04 : 8'h00);
         wrr(ofs[i], 8'hFF);
         rchk("dir rw", ofs[i], msk[i]);
      end
      chk("p0 dir", 12'hB, p0d);
      chk("p1 dir", 12'h7F, p1d);
      chk("p3 dir", 12'hFF, p3d);
      chk("p5 dir", 12'h3F, p5d);
      wrr(OFS_P0_DIR, 8'h00);
      cyc(2);
      chk("p0 in", 12'h0, p0d);
      rchk("unmapped", 8'h00, 8'h00);
      wrr(OFS_P1_WAKE, 8'h01);
      rchk("wake wo", OFS_P1_WAKE, 8'h00);
      wrr(OFS_CPU_CTRL, 8'h10);
      cyc(2);
      chk("seg", 12'h1, seg);
      rchk("ctrl", OFS_CPU_CTRL, 8'h10);
      wrr(OFS_IRQ_MASK, 8'h07);
      wrr(OFS_CPU_CTRL, 8'h03);
      cyc(2);
      chk("mode 11", 12'h0, {stop, halt});
      wrr(OFS_CPU_CTRL, 8'h01);
      cyc(1);
      chk("sleep", 12'h7, {stop, halt, mode == MODE_SLEEP});
      pin(11'h020, 4'h3);
      ovf();
      cyc(10);
      chk("no wake", 12'h1, stop);
      pin(11'h010, 4'h5);
      for (n = 0; stop && n < 40; n++) cyc(1);
      for (n = 0; halt && n < 3000; n++) cyc(1);
      chk("warm-up", 12'h800, n[11:0]);
      chk("normal", 12'h0, {slow, mode});
      rchk("status", OFS_IRQ_STAT, 8'h05);
      chk("irq on", 12'h1, irq);
      wrr(OFS_IRQ_STAT, 8'h07);
      cyc(2);
      chk("irq clr", 12'h0, irq);
      wrr(OFS_CPU_CTRL, 8'h06);
      cyc(1);
      chk("green", 12'h3, {stop, halt, mode == MODE_GREEN});
      ovf();
      cyc(3);
      chk("tmr off", 12'h1, halt);
      pin(11'h001, 4'h0);
      for (n = 0; halt && n < 10; n++) cyc(1);
      chk("green lag", 12'h2, n[11:0]);
      chk("slow kept", 12'h4, {slow, mode});
      wrr(OFS_CPU_CTRL, 8'h0A);
      cyc(1);
      ovf();
      cyc(0);
      chk("tmr wake", 12'h0, {halt, slow});
      rchk("status", OFS_IRQ_STAT, 8'h03);
      wrr(OFS_IRQ_MASK, 8'h00);
      cyc(2);
      chk("masked", 12'h0, irq);
      wrr(OFS_IRQ_MASK, 8'h02);
      cyc(2);
      chk("unmasked", 12'h1, irq);
      wrr(OFS_IRQ_STAT, 8'h03);
      cyc(2);
      chk("cleared", 12'h0, irq);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      chk("p3 reset", 12'h0, {p3d, p1d[3:0]});
      summarize();
   end
endmodule
`default_nettype wire
